// >>> isp_regs.svh
// Operation
// - Extensions start only after the enable command
// - Failed erase or program drives error low
// - Error holds until clear, or reset after disable
// - Status high while flash is readable
// - Status low during program, sector erase and chip erase cycles
// - Enable command may select pull-low-only drive
// - Secured part refuses all content reads
// - Secured part accepts only full chip erase
// - Chip erase blanks part and clears security
// - Protected sector refuses sector erase
// - Blank part: memory ones, configuration zeros
// - Pin-enable bit 0 switches test port
// - Dedicated pins ignore device reset
// - Register-enabled pins abort on device reset
// - Pins enabled by OR of three sources
// - Pin-enable register at offset c7 from base
// - Device reset or software clears enable bit
`ifndef ISP_REGS_SVH
`define ISP_REGS_SVH

// Register map, offset from the I/O register base.
`define PIN_ENABLE_OFS 8'hc7
`define PIN_ENABLE_BIT 0
`define PIN_ENABLE_RST 1'b0

// Scan register sizes and capture pattern.
`define IR_W 4
`define DR_W 16
`define IR_CAPTURE 4'h1

// Instruction codes.
`define CMD_CONFIG_ENABLE 4'h1
`define CMD_CONFIG_DISABLE 4'h2
`define CMD_CLEAR_ERROR 4'h3
`define CMD_PROGRAM 4'h4
`define CMD_ERASE_SECTOR 4'h5
`define CMD_ERASE_CHIP 4'h6
`define CMD_READ 4'h7
`define CMD_SET_SECURITY 4'h8
`define CMD_SET_PROTECT 4'h9
`define CMD_BYPASS 4'hf

// Fields of the enable command's data word.
`define DR_EXT_ON_BIT 0
`define DR_OPEN_DRAIN_BIT 1

// Memory geometry and blank values.
`define SECTOR_COUNT 12
`define SECTOR_BYTES 16
`define BLANK_BYTE 8'hff
`define BLANK_CFG 1'b0

// Flash cycle lengths in clock cycles.
`define PROG_CYCLES 16
`define ERASE_CYCLES 64

`endif

// >>> isp_pkg.sv
package isp_pkg;

   // Test access port controller states.
   typedef enum logic [3:0] {
      TL_RESET, RUN_IDLE, SEL_DR, CAP_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR,
      UPD_DR, SEL_IR, CAP_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR, UPD_IR
   } tap_state_e;

   // Flash cycle in progress.
   typedef enum logic [1:0] {
      OP_IDLE, OP_PROGRAM, OP_ERASE_SECTOR, OP_ERASE_CHIP
   } flash_op_e;

   // Pins that arrive from outside the clock domain.
   typedef struct packed {
      logic tck;
      logic tms;
      logic tdi;
      logic chip_reset_n;
   } pins_s;

   // Extension pin configuration chosen by the enable command.
   typedef struct packed {
      logic on;
      logic open_drain;
   } ext_cfg_s;

endpackage

// >>> isp_sync.sv
`timescale 1ns/10ps
// Two-flop synchroniser for a bundle of asynchronous pins.
module isp_sync #(
   parameter int W = 4,
   parameter logic [W-1:0] INIT = '0
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic reset,
   // Raw and synchronised levels.
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_reg;

   // The first stage feeds only the second stage.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         meta_reg <= INIT;
         q <= INIT;
      end else begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end
endmodule // isp_sync

// >>> isp_status_security_ctrl.sv
`timescale 1ns/10ps
`include "isp_regs.svh"
// Test port with status and error extensions, security lock and sector protection.
module isp_status_security_ctrl #(
   parameter int PROG_CYCLES = `PROG_CYCLES,
   parameter int ERASE_CYCLES = `ERASE_CYCLES,
   parameter int SECTORS = `SECTOR_COUNT,
   parameter int SECTOR_BYTES = `SECTOR_BYTES
) (
   // Clock and power-on reset.
   input wire logic clk,
   input wire logic reset,
   // Serial test pins and device reset pin.
   input wire logic tck_pin,
   input wire logic tms_pin,
   input wire logic tdi_pin,
   input wire logic chip_reset_n_pin,
   output logic tdo_out,
   output logic tdo_oe,
   // Extension pins.
   output logic isp_status_out,
   output logic isp_status_oe,
   output logic isp_error_out,
   output logic isp_error_oe,
   // Microcontroller register port.
   input wire logic [7:0] mcu_offset,
   input wire logic [7:0] mcu_wdata,
   input wire logic mcu_wr,
   input wire logic mcu_rd,
   output logic [7:0] mcu_rdata,
   // Pin-enable sources and result.
   input wire logic nvm_dedicate,
   input wire logic product_term_pin_select,
   output logic tap_pins_enabled
);
   localparam int BYTES = SECTORS * SECTOR_BYTES;
   localparam int CW = 16;

   // Refuse geometries and counts the logic cannot hold.
   if (BYTES > 256 || SECTORS > 16 || PROG_CYCLES < 1 || ERASE_CYCLES < 1 ||
       PROG_CYCLES >= 2**CW || ERASE_CYCLES >= 2**CW) begin : g_bad_param
      $error("isp_status_security_ctrl: unsupported parameter values");
   end

   function automatic logic [3:0] sector_of(input logic [7:0] a);
      sector_of = 4'(int'(a) / SECTOR_BYTES);
   endfunction

   function automatic isp_pkg::tap_state_e tap_step(input isp_pkg::tap_state_e s,
                                                   input logic m);
      case (s)
         isp_pkg::TL_RESET: tap_step = m ? isp_pkg::TL_RESET : isp_pkg::RUN_IDLE;
         isp_pkg::RUN_IDLE: tap_step = m ? isp_pkg::SEL_DR : isp_pkg::RUN_IDLE;
         isp_pkg::SEL_DR: tap_step = m ? isp_pkg::SEL_IR : isp_pkg::CAP_DR;
         isp_pkg::CAP_DR: tap_step = m ? isp_pkg::EXIT1_DR : isp_pkg::SHIFT_DR;
         isp_pkg::SHIFT_DR: tap_step = m ? isp_pkg::EXIT1_DR : isp_pkg::SHIFT_DR;
         isp_pkg::EXIT1_DR: tap_step = m ? isp_pkg::UPD_DR : isp_pkg::PAUSE_DR;
         isp_pkg::PAUSE_DR: tap_step = m ? isp_pkg::EXIT2_DR : isp_pkg::PAUSE_DR;
         isp_pkg::EXIT2_DR: tap_step = m ? isp_pkg::UPD_DR : isp_pkg::SHIFT_DR;
         isp_pkg::UPD_DR: tap_step = m ? isp_pkg::SEL_DR : isp_pkg::RUN_IDLE;
         isp_pkg::SEL_IR: tap_step = m ? isp_pkg::TL_RESET : isp_pkg::CAP_IR;
         isp_pkg::CAP_IR: tap_step = m ? isp_pkg::EXIT1_IR : isp_pkg::SHIFT_IR;
         isp_pkg::SHIFT_IR: tap_step = m ? isp_pkg::EXIT1_IR : isp_pkg::SHIFT_IR;
         isp_pkg::EXIT1_IR: tap_step = m ? isp_pkg::UPD_IR : isp_pkg::PAUSE_IR;
         isp_pkg::PAUSE_IR: tap_step = m ? isp_pkg::EXIT2_IR : isp_pkg::PAUSE_IR;
         isp_pkg::EXIT2_IR: tap_step = m ? isp_pkg::UPD_IR : isp_pkg::SHIFT_IR;
         isp_pkg::UPD_IR: tap_step = m ? isp_pkg::SEL_DR : isp_pkg::RUN_IDLE;
         default: tap_step = isp_pkg::TL_RESET;
      endcase
   endfunction

   isp_pkg::pins_s pin_raw;
   isp_pkg::pins_s pin_q;
   logic tck_d_reg;
   logic tck_rise;
   logic tck_fall;
   logic warm_rst;
   logic tap_active;

   // Synchronise the pins; device reset idles released.
   assign pin_raw = '{tck: tck_pin, tms: tms_pin, tdi: tdi_pin, chip_reset_n: chip_reset_n_pin};

   isp_sync #(
      .W($bits(isp_pkg::pins_s)),
      .INIT(4'h1)
   ) u_sync (
      .clk(clk),
      .reset(reset),
      .d(pin_raw),
      .q(pin_q)
   );

   // Test clock edges and the reset pin level, all on synchronised copies.
   assign tck_rise = pin_q.tck & ~tck_d_reg;
   assign tck_fall = ~pin_q.tck & tck_d_reg;
   assign warm_rst = ~pin_q.chip_reset_n;

   isp_pkg::tap_state_e tap_reg, tap_next;
   logic [`IR_W-1:0] ir_sh_reg, ir_sh_next, ir_reg, ir_next;
   logic [`DR_W-1:0] dr_reg, dr_next;
   logic tdo_reg, tdo_next, tdo_oe_reg, tdo_oe_next;
   logic cmd_fire;

   isp_pkg::flash_op_e op_reg, op_next;
   logic [CW-1:0] cnt_reg, cnt_next;
   logic [7:0] op_addr_reg, op_addr_next, op_data_reg, op_data_next;
   logic [7:0] mem [BYTES];
   logic [7:0] mem_next [BYTES];

   isp_pkg::ext_cfg_s ext_reg, ext_next;
   logic isc_en_reg, isc_en_next;
   logic disabled_reg, disabled_next;
   logic err_reg, err_next;
   logic secure_reg, secure_next;
   logic [SECTORS-1:0] protect_reg, protect_next;
   logic sw_en_reg, sw_en_next;
   logic [7:0] rdata_next;
   logic busy;
   logic err_set;
   logic err_clr;
   logic [7:0] cmd_addr;
   logic addr_ok;

   assign busy = op_reg != isp_pkg::OP_IDLE;
   assign cmd_addr = dr_reg[7:0];
   assign addr_ok = int'(cmd_addr) < BYTES;

   // Pins follow the OR of three sources; reset halts register- and product-term-enabled ones.
   assign tap_active = nvm_dedicate |
                       ((sw_en_reg | product_term_pin_select) & ~warm_rst);

   // Test access port controller, scan registers and output data.
   always_comb begin
      tap_next = tap_reg;
      ir_sh_next = ir_sh_reg;
      ir_next = ir_reg;
      dr_next = dr_reg;
      tdo_next = tdo_reg;
      tdo_oe_next = tdo_oe_reg;
      cmd_fire = 1'b0;
      if (!tap_active) begin
         tap_next = isp_pkg::TL_RESET;
         ir_next = `CMD_BYPASS;
         tdo_oe_next = 1'b0;
      end else if (tck_rise) begin
         tap_next = tap_step(tap_reg, pin_q.tms);
         case (tap_reg)
            isp_pkg::TL_RESET: ir_next = `CMD_BYPASS;
            isp_pkg::CAP_IR: ir_sh_next = `IR_CAPTURE;
            isp_pkg::SHIFT_IR: ir_sh_next = {pin_q.tdi, ir_sh_reg[`IR_W-1:1]};
            isp_pkg::UPD_IR: ir_next = ir_sh_reg;
            isp_pkg::CAP_DR: begin
               if (ir_reg == `CMD_READ) begin
                  dr_next[15:8] = 8'h00;
                  if (isc_en_reg && !secure_reg && !busy && addr_ok) begin
                     dr_next[15:8] = mem[cmd_addr];
                  end
               end else begin
                  dr_next = {8'h00, 3'h0, busy, err_reg, secure_reg, ext_reg};
               end
            end
            isp_pkg::SHIFT_DR: dr_next = {pin_q.tdi, dr_reg[`DR_W-1:1]};
            isp_pkg::UPD_DR: cmd_fire = 1'b1;
            default: ;
         endcase
      end else if (tck_fall) begin
         tdo_next = (tap_reg == isp_pkg::SHIFT_IR) ? ir_sh_reg[0] : dr_reg[0];
         tdo_oe_next = (tap_reg == isp_pkg::SHIFT_IR) || (tap_reg == isp_pkg::SHIFT_DR);
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         tck_d_reg <= 1'b0;
         tap_reg <= isp_pkg::TL_RESET;
         ir_sh_reg <= '0;
         ir_reg <= `CMD_BYPASS;
         dr_reg <= '0;
         tdo_reg <= 1'b0;
         tdo_oe_reg <= 1'b0;
      end else begin
         tck_d_reg <= pin_q.tck;
         tap_reg <= tap_next;
         ir_sh_reg <= ir_sh_next;
         ir_reg <= ir_next;
         dr_reg <= dr_next;
         tdo_reg <= tdo_next;
         tdo_oe_reg <= tdo_oe_next;
      end
   end

   // Command decode, flash cycles, configuration and error flag.
   always_comb begin
      op_next = op_reg;
      cnt_next = cnt_reg;
      op_addr_next = op_addr_reg;
      op_data_next = op_data_reg;
      ext_next = ext_reg;
      isc_en_next = isc_en_reg;
      disabled_next = disabled_reg;
      secure_next = secure_reg;
      protect_next = protect_reg;
      err_set = 1'b0;
      err_clr = 1'b0;
      for (int i = 0; i < BYTES; i++) begin
         mem_next[i] = mem[i];
      end
      if (!tap_active) begin
         op_next = isp_pkg::OP_IDLE;
         cnt_next = '0;
      end else if (busy) begin
         cnt_next = cnt_reg - CW'(1);
         if (cnt_reg == CW'(1)) begin
            op_next = isp_pkg::OP_IDLE;
            case (op_reg)
               isp_pkg::OP_PROGRAM: begin
                  mem_next[op_addr_reg] = mem[op_addr_reg] & op_data_reg;
                  err_set = (mem[op_addr_reg] & op_data_reg) != op_data_reg;
               end
               isp_pkg::OP_ERASE_SECTOR: begin
                  for (int i = 0; i < BYTES; i++) begin
                     if (sector_of(8'(i)) == op_addr_reg[3:0]) begin
                        mem_next[i] = `BLANK_BYTE;
                     end
                  end
               end
               isp_pkg::OP_ERASE_CHIP: begin
                  for (int i = 0; i < BYTES; i++) begin
                     mem_next[i] = `BLANK_BYTE;
                  end
                  protect_next = '0;
                  secure_next = `BLANK_CFG;
               end
               default: ;
            endcase
         end
      end else if (cmd_fire) begin
         case (ir_reg)
            `CMD_CONFIG_ENABLE: begin
               isc_en_next = 1'b1;
               disabled_next = 1'b0;
               ext_next.on = dr_reg[`DR_EXT_ON_BIT];
               ext_next.open_drain = dr_reg[`DR_OPEN_DRAIN_BIT];
            end
            `CMD_CONFIG_DISABLE: begin
               isc_en_next = 1'b0;
               disabled_next = 1'b1;
               ext_next = '0;
            end
            `CMD_CLEAR_ERROR: err_clr = 1'b1;
            `CMD_PROGRAM: begin
               if (isc_en_reg && !secure_reg) begin
                  if (addr_ok) begin
                     op_next = isp_pkg::OP_PROGRAM;
                     cnt_next = CW'(PROG_CYCLES);
                     op_addr_next = cmd_addr;
                     op_data_next = dr_reg[15:8];
                  end else begin
                     err_set = 1'b1;
                  end
               end
            end
            `CMD_ERASE_SECTOR: begin
               if (isc_en_reg && !secure_reg) begin
                  if (cmd_addr[3:0] >= SECTORS[3:0] || protect_reg[cmd_addr[3:0]]) begin
                     err_set = 1'b1;
                  end else begin
                     op_next = isp_pkg::OP_ERASE_SECTOR;
                     cnt_next = CW'(ERASE_CYCLES);
                     op_addr_next = {4'h0, cmd_addr[3:0]};
                  end
               end
            end
            `CMD_ERASE_CHIP: begin
               if (isc_en_reg) begin
                  op_next = isp_pkg::OP_ERASE_CHIP;
                  cnt_next = CW'(ERASE_CYCLES);
               end
            end
            `CMD_SET_SECURITY: begin
               if (isc_en_reg) begin
                  secure_next = 1'b1;
               end
            end
            `CMD_SET_PROTECT: begin
               if (isc_en_reg && !secure_reg && cmd_addr[3:0] < SECTORS[3:0]) begin
                  protect_next[cmd_addr[3:0]] = 1'b1;
               end
            end
            default: ;
         endcase
      end
      // A reset pulse after the disable command also clears the flag.
      if (warm_rst && disabled_reg) begin
         err_clr = 1'b1;
      end
      err_next = err_set | (err_reg & ~err_clr);
   end

   // Software pin-enable bit; device reset clears it.
   always_comb begin
      sw_en_next = sw_en_reg;
      if (warm_rst) begin
         sw_en_next = `PIN_ENABLE_RST;
      end else if (mcu_wr && mcu_offset == `PIN_ENABLE_OFS) begin
         sw_en_next = mcu_wdata[`PIN_ENABLE_BIT];
      end
      rdata_next = 8'h00;
      if (mcu_rd && mcu_offset == `PIN_ENABLE_OFS) begin
         rdata_next = {7'h00, sw_en_reg};
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         op_reg <= isp_pkg::OP_IDLE;
         cnt_reg <= '0;
         op_addr_reg <= 8'h00;
         op_data_reg <= 8'h00;
         ext_reg <= '0;
         isc_en_reg <= 1'b0;
         disabled_reg <= 1'b0;
         err_reg <= 1'b0;
         secure_reg <= `BLANK_CFG;
         protect_reg <= '0;
         sw_en_reg <= `PIN_ENABLE_RST;
         mcu_rdata <= 8'h00;
      end else begin
         op_reg <= op_next;
         cnt_reg <= cnt_next;
         op_addr_reg <= op_addr_next;
         op_data_reg <= op_data_next;
         ext_reg <= ext_next;
         isc_en_reg <= isc_en_next;
         disabled_reg <= disabled_next;
         err_reg <= err_next;
         secure_reg <= secure_next;
         protect_reg <= protect_next;
         sw_en_reg <= sw_en_next;
         mcu_rdata <= rdata_next;
      end
   end

   // Flash array; power-on reset models the blank part.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         for (int i = 0; i < BYTES; i++) begin
            mem[i] <= `BLANK_BYTE;
         end
      end else begin
         for (int i = 0; i < BYTES; i++) begin
            mem[i] <= mem_next[i];
         end
      end
   end

   // Extension pins: released until enabled, pull-low-only when open drain.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         isp_status_out <= 1'b0;
         isp_status_oe <= 1'b0;
         isp_error_out <= 1'b0;
         isp_error_oe <= 1'b0;
         tdo_out <= 1'b0;
         tdo_oe <= 1'b0;
         tap_pins_enabled <= 1'b0;
      end else begin
         isp_status_out <= ext_next.on & ~ext_next.open_drain & ~(op_next != isp_pkg::OP_IDLE);
         isp_status_oe <= ext_next.on &
                          (~ext_next.open_drain | (op_next != isp_pkg::OP_IDLE));
         isp_error_out <= ext_next.on & ~ext_next.open_drain & ~err_next;
         isp_error_oe <= ext_next.on & (~ext_next.open_drain | err_next);
         tdo_out <= tdo_next;
         tdo_oe <= tdo_oe_next;
         tap_pins_enabled <= tap_active;
      end
   end
endmodule // isp_status_security_ctrl

// >>> isp_status_security_ctrl_props.sv
`timescale 1ns/10ps
// Checks extension pins, pin enabling and register reads at the block's ports.
module isp_status_security_ctrl_props (
   // Clock and reset.
   input wire logic clk,
   input wire logic reset,
   // Test pins.
   input wire logic tck_pin,
   input wire logic tms_pin,
   input wire logic tdi_pin,
   input wire logic chip_reset_n_pin,
   input wire logic tdo_out,
   input wire logic tdo_oe,
   // Extension pins.
   input wire logic isp_status_out,
   input wire logic isp_status_oe,
   input wire logic isp_error_out,
   input wire logic isp_error_oe,
   // Register port and enable sources.
   input wire logic [7:0] mcu_offset,
   input wire logic [7:0] mcu_wdata,
   input wire logic mcu_wr,
   input wire logic mcu_rd,
   input wire logic [7:0] mcu_rdata,
   input wire logic nvm_dedicate,
   input wire logic product_term_pin_select,
   input wire logic tap_pins_enabled
);
   logic tck_d_reg;
   logic tck_d_next;
   logic [3:0] quiet_reg;
   logic [3:0] quiet_next;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);
   // Clocks since the last TCK rise or device reset.
   always_comb begin
      tck_d_next = tck_pin;
      quiet_next = quiet_reg + {3'h0, quiet_reg != 4'hf};
      if ((tck_pin && !tck_d_reg) || !chip_reset_n_pin) begin
         quiet_next = 4'h0;
      end
   end
   // Registers the helper state.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         tck_d_reg <= 1'b0;
         quiet_reg <= 4'hf;
      end else begin
         tck_d_reg <= tck_d_next;
         quiet_reg <= quiet_next;
      end
   end
   // An undriven extension pin never shows a high level.
   status_idle_low_a: assert property (!isp_status_oe |-> !isp_status_out)
      else $error("status pin high while not driven");
   error_idle_low_a: assert property (!isp_error_oe |-> !isp_error_out)
      else $error("error pin high while not driven");
   // The error flag leaves its active level, and busy starts, only shortly after a command or device reset.
   error_held_a: assert property (isp_error_oe && !isp_error_out && quiet_reg > 4'h9
      |=> isp_error_oe && !isp_error_out) else $error("error flag dropped on its own");
   busy_on_command_a: assert property ($rose(isp_status_oe && !isp_status_out)
      |-> quiet_reg < 4'ha) else $error("busy started without a command");
   // Pin enable sources and the register.
   dedicate_enables_a: assert property (nvm_dedicate [*3] |-> tap_pins_enabled)
      else $error("dedicated pins not enabled");
   read_upper_zero_a: assert property (mcu_rd |=> mcu_rdata[7:1] == 7'h00)
      else $error("unused register bits read nonzero");
   read_other_zero_a: assert property (mcu_rd && mcu_offset != 8'hc7 |=> mcu_rdata == 8'h00)
      else $error("unmapped offset read nonzero");
   write_enables_a: assert property (mcu_wr && mcu_offset == 8'hc7 && mcu_wdata[0]
      && chip_reset_n_pin && $past(chip_reset_n_pin, 3) |-> ##2 tap_pins_enabled)
      else $error("enable write did not enable the pins");
   write_clears_a: assert property (mcu_wr && mcu_offset == 8'hc7 && !mcu_wdata[0]
      && !nvm_dedicate && !product_term_pin_select
      ##1 (!nvm_dedicate && !product_term_pin_select && !mcu_wr) [*2] |-> !tap_pins_enabled)
      else $error("disable write left the pins enabled");
   reset_blocks_a: assert property ((!chip_reset_n_pin && !nvm_dedicate
      && !product_term_pin_select) [*6] |-> !tap_pins_enabled)
      else $error("pins enabled during device reset");
endmodule // isp_status_security_ctrl_props

bind isp_status_security_ctrl isp_status_security_ctrl_props i_props (.*);

// >>> isp_prog_model.sv
`timescale 1ns/10ps
// Programming controller driving the test link with TCK at one eighth of the clock.
module isp_prog_model (
   // Bench clock.
   input wire logic clk,
   // Test link.
   output logic tck,
   output logic tms,
   output logic tdi,
   input wire logic tdo
);
   // Link starts parked with TCK low.
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
   end
   // One TCK period: TMS and TDI change at the fall, TDO is taken at the rise.
   task automatic tick(input logic m, input logic d, output logic o);
      tck <= 1'b0;
      tms <= m;
      tdi <= d;
      repeat (4) @(posedge clk);
      o = tdo;
      tck <= 1'b1;
      repeat (4) @(posedge clk);
   endtask
   // Five TMS highs reach reset, one low reaches idle; TCK then stands low.
   task automatic reset_tap();
      logic o;
      repeat (5) tick(1'b1, ~tdi, o);
      tick(1'b0, ~tdi, o);
      tck <= 1'b0;
      @(posedge clk);
   endtask
   // IR or DR scan from idle, LSB first; the rise leaving update executes it.
   task automatic scan(input logic ir, input logic [15:0] v, input int n, output logic [15:0] cap);
      logic o;
      cap = 16'h0000;
      tick(1'b1, ~tdi, o);
      if (ir) tick(1'b1, ~tdi, o);
      tick(1'b0, ~tdi, o);
      tick(1'b0, ~tdi, o);
      for (int i = 0; i < n; i++) begin
         tick(i == n - 1, v[i], o);
         cap[i] = o;
      end
      tick(1'b1, ~tdi, o);
      tick(1'b0, ~tdi, o);
      tck <= 1'b0;
      @(posedge clk);
   endtask
endmodule // isp_prog_model

// >>> testbench.sv
`timescale 1ns/10ps
`include "isp_regs.svh"
// Self-checking bench: tasks note expectations, a watcher compares each result.
module testbench;
   logic clk, reset, tck_pin, tms_pin, tdi_pin, chip_reset_n_pin, tdo_out, tdo_oe;
   logic isp_status_out, isp_status_oe, isp_error_out, isp_error_oe, mcu_wr, mcu_rd;
   logic nvm_dedicate, product_term_pin_select, tap_pins_enabled;
   logic [7:0] mcu_offset, mcu_wdata, mcu_rdata, ofs;
   wire tdo_line;
   logic [15:0] exp_q[$];
   logic [15:0] seen;
   event seen_ev;
   int fails = 0, total_checks = 0, seed = 27;

   // TDO floats while the block is not shifting.
   assign tdo_line = tdo_oe ? tdo_out : 1'bz;

   // Device with short flash cycles, and the controller model.
   isp_status_security_ctrl #(.PROG_CYCLES(12), .ERASE_CYCLES(12)) i_isp_status_security_ctrl (.*);
   isp_prog_model i_model (.clk, .tck(tck_pin), .tms(tms_pin), .tdi(tdi_pin), .tdo(tdo_line));

   // Clock at 25 ns.
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // Prints the verdict and ends the run.
   task automatic results();
      if (fails == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // Compares one result with its note.
   task automatic check(input logic [15:0] got, input logic [15:0] want);
      total_checks++;
      if (got !== want) begin
         fails++;
         $display("wrong value at %0t: seen %h expected %h", $time, got, want);
      end
   endtask
   // Watcher takes the oldest note for each result.
   initial begin
      forever begin
         @(seen_ev);
         check(seen, exp_q.pop_front());
      end
   end
   // Queueing and handing over of results.
   task automatic note(input logic [15:0] v);
      exp_q.push_back(v);
   endtask
   task automatic give(input logic [15:0] v);
      seen = v;
      -> seen_ev;
      @(posedge clk);
   endtask
   task automatic pin(input logic [15:0] e);
      note(e);
      give({12'h000, isp_status_oe, isp_status_out, isp_error_oe, isp_error_out});
   endtask
   task automatic en_bit(input logic [15:0] e);
      note(e);
      give({15'h0000, tap_pins_enabled});
   endtask
   // Register writes and reads.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      mcu_offset <= a;
      mcu_wdata <= d;
      mcu_wr <= 1'b1;
      @(posedge clk);
      mcu_wr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] a);
      mcu_offset <= a;
      mcu_rd <= 1'b1;
      @(posedge clk);
      mcu_rd <= 1'b0;
      #1;
      give({8'h00, mcu_rdata});
   endtask
   // Scans; every IR scan checks the capture pattern.
   task automatic ir(input logic [3:0] c);
      logic [15:0] cap;
      i_model.scan(1'b1, {12'h000, c}, 4, cap);
      note({12'h000, `IR_CAPTURE});
      give(cap);
   endtask
   task automatic dr(input logic [15:0] v, input logic chk);
      logic [15:0] cap;
      i_model.scan(1'b0, v, 16, cap);
      if (chk) give(cap);
   endtask
   // Bounded wait for the status pin to leave its busy level.
   task automatic wait_ready();
      int n;
      n = 0;
      repeat (3) @(posedge clk);
      while (isp_status_oe && !isp_status_out) begin
         n++;
         if (n > 400) begin
            fails++;
            results();
         end
         @(posedge clk);
      end
      repeat (2) @(posedge clk);
   endtask
   // Starts a flash command and checks the busy level two clocks on.
   task automatic busy(input logic [15:0] v, input logic [15:0] pins);
      dr(v, 1'b0);
      repeat (2) @(posedge clk);
      pin(pins);
      wait_ready();
   endtask

   // Main sequence.
   initial begin
      reset = 1'b1;
      chip_reset_n_pin = 1'b1;
      mcu_offset = 8'h00;
      mcu_wdata = 8'h00;
      mcu_wr = 1'b0;
      mcu_rd = 1'b0;
      nvm_dedicate = 1'b0;
      product_term_pin_select = 1'b0;
      repeat (4) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      pin(16'h0000);
      note(16'h0000);
      rd(`PIN_ENABLE_OFS);
      ofs = 8'($random(seed));
      if (ofs == `PIN_ENABLE_OFS) ofs = 8'h00;
      wr(ofs, 8'($random(seed)));
      note(16'h0000);
      rd(ofs);
      wr(`PIN_ENABLE_OFS, 8'h01);
      note(16'h0001);
      rd(`PIN_ENABLE_OFS);
      en_bit(16'h0001);
      i_model.reset_tap();
      ir(`CMD_CONFIG_ENABLE);
      dr(16'h0001, 1'b0);
      pin(16'h000f);
      ir(`CMD_PROGRAM);
      busy(16'h0000, 16'h000b);
      pin(16'h000f);
      busy(16'hff00, 16'h000b);
      pin(16'h000e);
      ir(`CMD_BYPASS);
      note(16'h000a);
      dr(16'h0000, 1'b1);
      ir(`CMD_CLEAR_ERROR);
      dr(16'h0000, 1'b0);
      pin(16'h000f);
      ir(`CMD_READ);
      dr(16'h0005, 1'b0);
      note(16'hff05);
      dr(16'h0000, 1'b1);
      note(16'h0000);
      dr(16'h0000, 1'b1);
      ir(`CMD_SET_PROTECT);
      dr(16'h0001, 1'b0);
      ir(`CMD_ERASE_SECTOR);
      dr(16'h0001, 1'b0);
      wait_ready();
      pin(16'h000e);
      ir(`CMD_CLEAR_ERROR);
      dr(16'h0000, 1'b0);
      ir(`CMD_ERASE_SECTOR);
      busy(16'h0000, 16'h000b);
      ir(`CMD_READ);
      dr(16'h0000, 1'b0);
      note(16'hff00);
      dr(16'h0000, 1'b1);
      ir(`CMD_SET_SECURITY);
      dr(16'h0000, 1'b0);
      ir(`CMD_READ);
      dr(16'h0005, 1'b0);
      note(16'h0005);
      dr(16'h0000, 1'b1);
      ir(`CMD_PROGRAM);
      busy(16'h0005, 16'h000f);
      ir(`CMD_BYPASS);
      note(16'h0006);
      dr(16'h0000, 1'b1);
      ir(`CMD_ERASE_CHIP);
      busy(16'h0000, 16'h000b);
      ir(`CMD_READ);
      dr(16'h0000, 1'b0);
      note(16'hff00);
      dr(16'h0000, 1'b1);
      ir(`CMD_CONFIG_ENABLE);
      dr(16'h0003, 1'b0);
      pin(16'h0000);
      ir(`CMD_PROGRAM);
      busy(16'hff00, 16'h0008);
      dr(16'h00c0, 1'b0);
      wait_ready();
      pin(16'h0002);
      ir(`CMD_CONFIG_DISABLE);
      dr(16'h0000, 1'b0);
      pin(16'h0000);
      chip_reset_n_pin <= 1'b0;
      repeat (8) @(posedge clk);
      en_bit(16'h0000);
      chip_reset_n_pin <= 1'b1;
      repeat (3) @(posedge clk);
      note(16'h0000);
      rd(`PIN_ENABLE_OFS);
      wr(`PIN_ENABLE_OFS, 8'h01);
      i_model.reset_tap();
      ir(`CMD_CONFIG_ENABLE);
      dr(16'h0001, 1'b0);
      pin(16'h000f);
      nvm_dedicate <= 1'b1;
      chip_reset_n_pin <= 1'b0;
      repeat (4) @(posedge clk);
      en_bit(16'h0001);
      ir(`CMD_BYPASS);
      chip_reset_n_pin <= 1'b1;
      nvm_dedicate <= 1'b0;
      wr(`PIN_ENABLE_OFS, 8'h00);
      repeat (3) @(posedge clk);
      en_bit(16'h0000);
      product_term_pin_select <= 1'b1;
      repeat (3) @(posedge clk);
      en_bit(16'h0001);
      results();
   end
endmodule // testbench
